// *** design/nvm_defs.svh ***
// Register map, field positions, reset values and timing for the nonvolatile controller
// Function
// - Data store holds 256 bytes, low address only
// - Program words: 14-bit data, 15-bit address
// - Data byte write erases then programs
// - Internal timer paces every write and erase except latch-only loads
// - Protected program regions refuse writes, reads allowed
// - Code protection blocks programmer, not the CPU
// - Memory select picks program or data
// - Start bits set-only, hardware clears on completion
// - Write enable clear inhibits all programming
// - Error flag on reset mid-write or start attempt
// - Done flag set by hardware, cleared by software
// - Unlock register always reads zero
// - Config select routes to configuration space
// - Latch-only loads latches, else programs all
// - Latch-only ignored for the data store
// - Erase select erases row, cleared after erase
// - Data store read completes in one cycle, bit clears
// - High data six bits, high address seven
// - Start needs write enable; later clear harmless
// - Program read uses the second following cycle
// - Program erase covers aligned 32-word row
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// Byte offsets on the register bus
`define NVM_OFF_DATA_LO   5'h00
`define NVM_OFF_DATA_HI   5'h04
`define NVM_OFF_ADDR_LO   5'h08
`define NVM_OFF_ADDR_HI   5'h0C
`define NVM_OFF_CONTROL   5'h10
`define NVM_OFF_UNLOCK    5'h14
`define NVM_OFF_STATUS    5'h18

// Control register fields
`define NVM_CTL_MEM_SEL   7
`define NVM_CTL_CFG_SEL   6
`define NVM_CTL_LATCH     5
`define NVM_CTL_ERASE     4
`define NVM_CTL_ERR       3
`define NVM_CTL_WRITE_ENABLE_BIT      2
`define NVM_CTL_WR        1
`define NVM_CTL_RD        0

// Status register fields
`define NVM_STAT_DONE     0
`define NVM_STAT_BUSY     1

// Unlock pattern and field masks
`define NVM_UNLOCK_1      8'h55
`define NVM_UNLOCK_2      8'hAA
`define NVM_DATA_HI_W     6
`define NVM_ADDR_HI_W     7
`define NVM_ROW_MASK      15'h7FE0
`define NVM_WP_ALL        2'b00
`define NVM_WP_HALF       2'b01
`define NVM_WP_EIGHTH     2'b10
`define NVM_WP_HALF_LIM   15'h4000
`define NVM_WP_EIGHT_LIM  15'h1000
`define NVM_RESET_BYTE    8'h00

// Self-timed write duration, least time rounded up to clock cycles
`define NVM_CLK_PERIOD_NS 40
`define NVM_WRITE_TIME_NS 4000000
`define NVM_WRITE_CYCLES  ((`NVM_WRITE_TIME_NS + `NVM_CLK_PERIOD_NS - 1) / `NVM_CLK_PERIOD_NS)

`endif

// *** design/nvm_pkg.sv ***
// Types shared by the nonvolatile access controller and its program array port
package nvm_pkg;

  // Program array operations, one-hot
  typedef enum logic [3:0] {
    NVM_OP_READ  = 4'b0001,
    NVM_OP_LATCH = 4'b0010,
    NVM_OP_PROG  = 4'b0100,
    NVM_OP_ERASE = 4'b1000
  } nvm_op_t;

  // Operation sequencer states
  typedef enum logic [2:0] {
    NVM_ST_IDLE  = 3'b001,
    NVM_ST_RDWT  = 3'b010,
    NVM_ST_WRITE = 3'b100
  } nvm_st_t;

  // Unlock sequence progress
  typedef enum logic [2:0] {
    NVM_UL_NONE = 3'b001,
    NVM_UL_FIRST = 3'b010,
    NVM_UL_ARMED = 3'b100
  } nvm_ul_t;

  // Request to the program flash array
  typedef struct packed {
    logic        valid;
    nvm_op_t     op;
    logic        cfg;
    logic [14:0] addr;
    logic [13:0] wdata;
  } nvm_pf_req_t;

endpackage : nvm_pkg

// *** design/nvm_ctrl.sv ***
// Nonvolatile memory access controller with data store and program array port
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "nvm_defs.svh"

module nvm_ctrl #(
  parameter int WRITE_CYCLES = `NVM_WRITE_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [1:0]           self_write_protect,
  input  wire logic                 code_protect,
  input  wire logic [13:0]          pf_rdata,
  output nvm_pkg::nvm_pf_req_t      pf_req,
  output logic                      prog_access_en,
  output logic                      nv_busy
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Protected program regions sit at the bottom of the array
  function automatic logic is_protected(input logic [14:0] a, input logic [1:0] wp);
    logic p;
    p = 1'b0;
    unique case (wp)
      `NVM_WP_ALL:    p = 1'b1;
      `NVM_WP_HALF:   p = (a < `NVM_WP_HALF_LIM);
      `NVM_WP_EIGHTH: p = (a < `NVM_WP_EIGHT_LIM);
      default:        p = 1'b0;
    endcase
    return p;
  endfunction : is_protected

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  logic [7:0]                        data_lo_r,  data_lo_nxt;
  logic [`NVM_DATA_HI_W-1:0]         data_hi_r,  data_hi_nxt;
  logic [7:0]                        addr_lo_r,  addr_lo_nxt;
  logic [`NVM_ADDR_HI_W-1:0]         addr_hi_r,  addr_hi_nxt;
  logic                              mem_sel_r,  mem_sel_nxt;
  logic                              cfg_sel_r,  cfg_sel_nxt;
  logic                              latch_r,    latch_nxt;
  logic                              erase_r,    erase_nxt;
  logic                              err_r,      err_nxt;
  logic                              write_enable_bit_r,     write_enable_bit_nxt;
  logic                              wr_r,       wr_nxt;
  logic                              rd_r,       rd_nxt;
  logic                              done_r,     done_nxt;
  logic                              ee_op_r,    ee_op_nxt;
  logic [23:0]                       tmr_r,      tmr_nxt;
  logic                              ack_r,      ack_nxt;
  logic [31:0]                       rdata_r,    rdata_nxt;
  logic                              post_rst_r;
  logic                              wip_mark_r, wip_mark_nxt;
  nvm_pkg::nvm_st_t                  st_r,       st_nxt;
  nvm_pkg::nvm_ul_t                  ul_r,       ul_nxt;
  nvm_pkg::nvm_pf_req_t              pf_r,       pf_nxt;
  logic                              ee_we;
  logic [7:0]                        ee_mem [256];

  logic                              wr_go;
  logic [7:0]                        wbyte;
  logic [14:0]                       word_addr;
  logic                              start_ok;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------

  // Every access waits one cycle so read data can come from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign ack_nxt         = (avs_read | avs_write) & ~ack_r;
  assign wr_go           = avs_write & ack_r & avs_byteenable[0];
  assign wbyte           = avs_writedata[7:0];
  assign avs_readdata    = rdata_r;
  assign pf_req          = pf_r;
  assign nv_busy         = (st_r != nvm_pkg::NVM_ST_IDLE);

  assign prog_access_en  = ~code_protect;

  assign word_addr = {addr_hi_r, addr_lo_r};

  assign start_ok = wr_go && (avs_address == `NVM_OFF_CONTROL) && wbyte[`NVM_CTL_WR]
                    && (ul_r == nvm_pkg::NVM_UL_ARMED) && write_enable_bit_r
                    && (st_r == nvm_pkg::NVM_ST_IDLE) && !wr_r;

  // ----------------------------------------------------------------
  // Read data capture
  // ----------------------------------------------------------------

  // Captured in the waiting cycle; unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      unique case (avs_address)
        `NVM_OFF_DATA_LO: rdata_nxt[7:0] = data_lo_r;
        `NVM_OFF_DATA_HI: rdata_nxt[`NVM_DATA_HI_W-1:0] = data_hi_r;
        `NVM_OFF_ADDR_LO: rdata_nxt[7:0] = addr_lo_r;
        `NVM_OFF_ADDR_HI: rdata_nxt[`NVM_ADDR_HI_W-1:0] = addr_hi_r;
        `NVM_OFF_CONTROL: rdata_nxt[7:0] = {mem_sel_r, cfg_sel_r, latch_r, erase_r,
                                            err_r, write_enable_bit_r, wr_r, rd_r};
        `NVM_OFF_UNLOCK:  rdata_nxt[7:0] = 8'h00;
        `NVM_OFF_STATUS:  begin
          rdata_nxt[`NVM_STAT_DONE] = done_r;
          rdata_nxt[`NVM_STAT_BUSY] = nv_busy;
        end
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Unlock tracking
  // ----------------------------------------------------------------

  always_comb begin
    ul_nxt = ul_r;
    if (wr_go) begin
      if (avs_address == `NVM_OFF_UNLOCK) begin
        if (wbyte == `NVM_UNLOCK_1)
          ul_nxt = nvm_pkg::NVM_UL_FIRST;
        else if (wbyte == `NVM_UNLOCK_2 && ul_r == nvm_pkg::NVM_UL_FIRST)
          ul_nxt = nvm_pkg::NVM_UL_ARMED;
        else
          ul_nxt = nvm_pkg::NVM_UL_NONE;
      end else begin
        // The arming is spent on the next write to any other register, used or not
        ul_nxt = nvm_pkg::NVM_UL_NONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers and operation sequencer
  // ----------------------------------------------------------------

  // Software writes are applied first so hardware set and clear win
  always_comb begin
    data_lo_nxt = data_lo_r;
    data_hi_nxt = data_hi_r;
    addr_lo_nxt = addr_lo_r;
    addr_hi_nxt = addr_hi_r;
    mem_sel_nxt = mem_sel_r;
    cfg_sel_nxt = cfg_sel_r;
    latch_nxt   = latch_r;
    erase_nxt   = erase_r;
    err_nxt     = err_r;
    write_enable_bit_nxt    = write_enable_bit_r;
    wr_nxt      = wr_r;
    rd_nxt      = rd_r;
    done_nxt    = done_r;
    ee_op_nxt   = ee_op_r;
    tmr_nxt     = tmr_r;
    st_nxt      = st_r;
    pf_nxt      = pf_r;
    pf_nxt.valid = 1'b0;
    ee_we       = 1'b0;

    if (wr_go) begin
      unique case (avs_address)
        `NVM_OFF_DATA_LO: data_lo_nxt = wbyte;
        `NVM_OFF_DATA_HI: data_hi_nxt = wbyte[`NVM_DATA_HI_W-1:0];
        `NVM_OFF_ADDR_LO: addr_lo_nxt = wbyte;
        `NVM_OFF_ADDR_HI: addr_hi_nxt = wbyte[`NVM_ADDR_HI_W-1:0];
        `NVM_OFF_CONTROL: begin
          mem_sel_nxt = wbyte[`NVM_CTL_MEM_SEL];
          cfg_sel_nxt = wbyte[`NVM_CTL_CFG_SEL];
          latch_nxt   = wbyte[`NVM_CTL_LATCH];
          erase_nxt   = wbyte[`NVM_CTL_ERASE];
          write_enable_bit_nxt    = wbyte[`NVM_CTL_WRITE_ENABLE_BIT];
          err_nxt     = wbyte[`NVM_CTL_ERR] | wbyte[`NVM_CTL_WR];
          if (start_ok)
            wr_nxt = 1'b1;
          if (wbyte[`NVM_CTL_RD] && st_r == nvm_pkg::NVM_ST_IDLE && !wr_r)
            rd_nxt = 1'b1;
        end
        `NVM_OFF_STATUS:  done_nxt = done_r & wbyte[`NVM_STAT_DONE];
        default:          ;
      endcase
    end

    unique case (st_r)
      nvm_pkg::NVM_ST_IDLE: begin
        if (rd_r) begin
          if (!mem_sel_r && !cfg_sel_r) begin
            data_lo_nxt = ee_mem[addr_lo_r];
            rd_nxt      = 1'b0;
          end else begin
            pf_nxt.valid = 1'b1;
            pf_nxt.op    = nvm_pkg::NVM_OP_READ;
            pf_nxt.cfg   = cfg_sel_r;
            pf_nxt.addr  = word_addr;
            st_nxt       = nvm_pkg::NVM_ST_RDWT;
          end
        end else if (wr_r) begin
          pf_nxt.cfg   = cfg_sel_r;
          pf_nxt.addr  = word_addr;
          pf_nxt.wdata = {data_hi_r, data_lo_r};
          tmr_nxt      = 24'(WRITE_CYCLES - 1);
          if (!mem_sel_r && !cfg_sel_r) begin
            ee_op_nxt = 1'b1;
            st_nxt    = nvm_pkg::NVM_ST_WRITE;
          end else if (!cfg_sel_r && is_protected(word_addr, self_write_protect)) begin
            wr_nxt  = 1'b0;
            err_nxt = 1'b1;
          end else if (erase_r) begin
            ee_op_nxt    = 1'b0;
            pf_nxt.valid = 1'b1;
            pf_nxt.op    = nvm_pkg::NVM_OP_ERASE;
            pf_nxt.addr  = word_addr & `NVM_ROW_MASK;
            st_nxt       = nvm_pkg::NVM_ST_WRITE;
          end else if (latch_r) begin
            pf_nxt.valid = 1'b1;
            pf_nxt.op    = nvm_pkg::NVM_OP_LATCH;
            wr_nxt       = 1'b0;
          end else begin
            ee_op_nxt    = 1'b0;
            pf_nxt.valid = 1'b1;
            pf_nxt.op    = nvm_pkg::NVM_OP_PROG;
            st_nxt       = nvm_pkg::NVM_ST_WRITE;
          end
        end
      end
      nvm_pkg::NVM_ST_RDWT: begin
        data_lo_nxt = pf_rdata[7:0];
        data_hi_nxt = pf_rdata[13:8];
        rd_nxt      = 1'b0;
        st_nxt      = nvm_pkg::NVM_ST_IDLE;
      end
      nvm_pkg::NVM_ST_WRITE: begin
        if (tmr_r == 24'h00_0000) begin
          ee_we    = ee_op_r;
          if (!ee_op_r && pf_r.op == nvm_pkg::NVM_OP_ERASE)
            erase_nxt = 1'b0;
          wr_nxt   = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = nvm_pkg::NVM_ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 24'h00_0001;
        end
      end
      default: st_nxt = nvm_pkg::NVM_ST_IDLE;
    endcase

    if (post_rst_r && wip_mark_r)
      err_nxt = 1'b1;
  end

  // ----------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------

  // Control state and bus answer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_lo_r  <= `NVM_RESET_BYTE;
      data_hi_r  <= '0;
      addr_lo_r  <= `NVM_RESET_BYTE;
      addr_hi_r  <= '0;
      mem_sel_r  <= 1'b0;
      cfg_sel_r  <= 1'b0;
      latch_r    <= 1'b0;
      erase_r    <= 1'b0;
      err_r      <= 1'b0;
      write_enable_bit_r     <= 1'b0;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      done_r     <= 1'b0;
      ee_op_r    <= 1'b0;
      tmr_r      <= 24'h00_0000;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      post_rst_r <= 1'b1;
      st_r       <= nvm_pkg::NVM_ST_IDLE;
      ul_r       <= nvm_pkg::NVM_UL_NONE;
      pf_r       <= '0;
    end else begin
      data_lo_r  <= data_lo_nxt;
      data_hi_r  <= data_hi_nxt;
      addr_lo_r  <= addr_lo_nxt;
      addr_hi_r  <= addr_hi_nxt;
      mem_sel_r  <= mem_sel_nxt;
      cfg_sel_r  <= cfg_sel_nxt;
      latch_r    <= latch_nxt;
      erase_r    <= erase_nxt;
      err_r      <= err_nxt;
      write_enable_bit_r     <= write_enable_bit_nxt;
      wr_r       <= wr_nxt;
      rd_r       <= rd_nxt;
      done_r     <= done_nxt;
      ee_op_r    <= ee_op_nxt;
      tmr_r      <= tmr_nxt;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
      post_rst_r <= 1'b0;
      st_r       <= st_nxt;
      ul_r       <= ul_nxt;
      pf_r       <= pf_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write-in-progress memory across reset
  // ----------------------------------------------------------------

  // Not reset on purpose: it must remember a write that reset cut short
  assign wip_mark_nxt = sys_rst ? wip_mark_r : (st_r == nvm_pkg::NVM_ST_WRITE);

  always_ff @(posedge clock) begin
    wip_mark_r <= wip_mark_nxt;
  end

  // ----------------------------------------------------------------
  // Data store array
  // ----------------------------------------------------------------

  always_ff @(posedge clock) begin
    if (ee_we)
      ee_mem[pf_r.addr[7:0]] <= pf_r.wdata[7:0];
  end

endmodule : nvm_ctrl

// *** verification/nvm_ctrl_assertions.sv ***
// Port-level assertions for the nonvolatile access controller
`timescale 1ns/1ns
`include "nvm_defs.svh"
module nvm_chk #(
  parameter int WRITE_CYCLES = 16
) (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic [4:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_writedata,
  input wire logic [3:0]           avs_byteenable,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [1:0]           self_write_protect,
  input wire logic                 code_protect,
  input wire logic [13:0]          pf_rdata,
  input wire nvm_pkg::nvm_pf_req_t pf_req,
  input wire logic                 prog_access_en,
  input wire logic                 nv_busy
);
  localparam int BUSY_MAX = WRITE_CYCLES + 6;
  int busy_cnt_r;
  int busy_cnt_nxt;
  // Busy run length; real write times are far beyond any delay range
  always_comb begin
    busy_cnt_nxt = nv_busy ? busy_cnt_r + 1 : 0;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // Bus and array port relations
  // ------------------------------
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence rd_ack(logic [4:0] off);
    avs_read && !avs_waitrequest && avs_address == off;
  endsequence
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("bus request not stalled in its first cycle");
  one_wait_a: assert property (bus_req |=> !avs_waitrequest)
    else $error("bus request stalled longer than one cycle");
  unlock_zero_a: assert property (rd_ack(`NVM_OFF_UNLOCK) |-> avs_readdata == '0)
    else $error("unlock register read not zero");
  data_hi_width_a: assert property (rd_ack(`NVM_OFF_DATA_HI) |-> avs_readdata[31:6] == '0)
    else $error("high data register upper bits not zero");
  addr_hi_width_a: assert property (rd_ack(`NVM_OFF_ADDR_HI) |-> avs_readdata[31:7] == '0)
    else $error("high address register upper bit not zero");
  prog_gate_a: assert property (prog_access_en == !code_protect)
    else $error("programmer access does not follow code protection");
  req_pulse_a: assert property (pf_req.valid |=> !pf_req.valid ##1 !pf_req.valid)
    else $error("array request longer than one cycle");
  row_align_a: assert property (pf_req.valid && pf_req.op == nvm_pkg::NVM_OP_ERASE
    |-> pf_req.addr[4:0] == 5'h00 && $onehot(pf_req.op))
    else $error("row erase address not row aligned");
  busy_bound_a: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("operation busy beyond its timed length");
endmodule : nvm_chk

bind nvm_ctrl nvm_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_nvm_chk (
  .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .self_write_protect(self_write_protect), .code_protect(code_protect),
  .pf_rdata(pf_rdata), .pf_req(pf_req), .prog_access_en(prog_access_en), .nv_busy(nv_busy)
);

// *** verification/nvm_pf_model.sv ***
// Behavioural program flash array facing the controller's program port
`timescale 1ns/1ns
module nvm_pf_model (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire nvm_pkg::nvm_pf_req_t pf_req,
  output logic [13:0]              pf_rdata
);
  logic [13:0] mem [logic [15:0]];
  logic [13:0] lat [logic [15:0]];
  logic [15:0] key;
  logic [13:0] junk_r;
  assign key = {pf_req.cfg, pf_req.addr};
  // ------------------------------
  // Array behaviour
  // ------------------------------
  // word read
  // The controller takes the word at the end of the pulse cycle, so it answers at once;
  // junk stands in every other cycle so stale use shows
  always_comb begin
    pf_rdata = junk_r;
    if (pf_req.valid && pf_req.op == nvm_pkg::NVM_OP_READ) begin
      pf_rdata = mem.exists(key) ? mem[key] : 14'h3FFF;
    end
  end
  // Writes land at the edge that ends the request pulse
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      junk_r <= 14'h0AAA;
    end else begin
      junk_r <= ~junk_r;
      if (pf_req.valid && (pf_req.op == nvm_pkg::NVM_OP_LATCH ||
                           pf_req.op == nvm_pkg::NVM_OP_PROG)) begin
        lat[key] = pf_req.wdata;
      end
      if (pf_req.valid && pf_req.op == nvm_pkg::NVM_OP_PROG) begin
        foreach (lat[k]) mem[k] = lat[k];
        lat.delete();
      end
      if (pf_req.valid && pf_req.op == nvm_pkg::NVM_OP_ERASE) begin
        for (int i = 0; i < 32; i++) mem[{key[15:5], i[4:0]}] = 14'h3FFF;
      end
    end
  end
endmodule : nvm_pf_model

// *** verification/test_nv_memory_access_ctrl.sv ***
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ns
`include "nvm_defs.svh"
module test_nv_memory_access_ctrl;
  typedef struct packed {
    logic [4:0] off;
    logic [7:0] wd;
    logic [7:0] exp;
  } nvm_row_t;
  logic                 clock;
  logic                 sys_rst;
  logic [4:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [3:0]           avs_byteenable;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [1:0]           self_write_protect;
  logic                 code_protect;
  logic [13:0]          pf_rdata;
  nvm_pkg::nvm_pf_req_t pf_req;
  logic                 prog_access_en;
  logic                 nv_busy;
  int                   miscompares;
  int                   check_count;
  logic [31:0]          q;
  nvm_row_t             rows [6];

  nvm_ctrl #(.WRITE_CYCLES(16)) dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .self_write_protect(self_write_protect), .code_protect(code_protect),
    .pf_rdata(pf_rdata), .pf_req(pf_req), .prog_access_en(prog_access_en), .nv_busy(nv_busy)
  );
  nvm_pf_model u_pf (.clock(clock), .sys_rst(sys_rst), .pf_req(pf_req), .pf_rdata(pf_rdata));

  // ------------------------------
  // Bus tasks and verdict
  // ------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Request held until waitrequest is seen low at an edge; data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h00_0000, d};
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      end_sim();
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check_count++;
    if ((q[7:0] & m) !== e || q[31:8] !== 24'h00_0000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, q, {24'h00_0000, e});
    end
  endtask : chk

  task automatic unlock_go(input logic [7:0] c);
    bus(1'b1, `NVM_OFF_UNLOCK, `NVM_UNLOCK_1);
    bus(1'b1, `NVM_OFF_UNLOCK, `NVM_UNLOCK_2);
    bus(1'b1, `NVM_OFF_CONTROL, c);
  endtask : unlock_go

  // Program read; data registers cleared first so a stale word cannot pass,
  // and one cycle let by since the array word lands two cycles after the start
  task automatic pf_read(input logic [7:0] c);
    bus(1'b1, `NVM_OFF_DATA_LO, 8'h00);
    bus(1'b1, `NVM_OFF_DATA_HI, 8'h00);
    bus(1'b1, `NVM_OFF_CONTROL, c);
    @(posedge clock);
  endtask : pf_read

  // Polls the busy bit; a bounded count stands in for a hang
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, `NVM_OFF_STATUS, 8'h00);
      n++;
    end while (q[`NVM_STAT_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin
      miscompares++;
      end_sim();
    end
  endtask : wait_idle

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h1;
    self_write_protect = 2'b11;
    code_protect = 1'b0;
    miscompares = 0;
    check_count = 0;
    rows = '{'{`NVM_OFF_ADDR_LO, 8'hFF, 8'hFF}, '{`NVM_OFF_ADDR_HI, 8'hFF, 8'h7F},
             '{`NVM_OFF_DATA_HI, 8'hFF, 8'h3F}, '{`NVM_OFF_DATA_LO, 8'h3C, 8'h3C},
             '{`NVM_OFF_UNLOCK, 8'h55, 8'h00}, '{5'h1C, 8'hFF, 8'h00}};
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    chk(`NVM_OFF_ADDR_HI, 8'hFF, 8'h00);
    chk(`NVM_OFF_CONTROL, 8'hF7, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].off, rows[i].wd);
      chk(rows[i].off, 8'hFF, rows[i].exp);
    end
    // A write with the low byte lane off is ignored
    avs_byteenable <= 4'h0;
    bus(1'b1, `NVM_OFF_ADDR_LO, 8'h5A);
    avs_byteenable <= 4'h1;
    chk(`NVM_OFF_ADDR_LO, 8'hFF, 8'hFF);
    // Start without write enable, then without the unlock pair
    unlock_go(8'h02);
    chk(`NVM_OFF_STATUS, 8'h02, 8'h00);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h04);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h06);
    chk(`NVM_OFF_CONTROL, 8'h0F, 8'h0C);
    // Unlock broken by another register write
    bus(1'b1, `NVM_OFF_UNLOCK, `NVM_UNLOCK_1);
    bus(1'b1, `NVM_OFF_DATA_LO, 8'h5A);
    bus(1'b1, `NVM_OFF_UNLOCK, `NVM_UNLOCK_2);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h06);
    chk(`NVM_OFF_STATUS, 8'h02, 8'h00);
    // Data byte write at the top address, latch-only set, enable dropped mid-write
    bus(1'b1, `NVM_OFF_CONTROL, 8'h24);
    unlock_go(8'h26);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h20);
    chk(`NVM_OFF_CONTROL, 8'h06, 8'h02);
    wait_idle();
    chk(`NVM_OFF_STATUS, 8'h01, 8'h01);
    chk(`NVM_OFF_CONTROL, 8'h02, 8'h00);
    bus(1'b1, `NVM_OFF_STATUS, 8'h00);
    chk(`NVM_OFF_STATUS, 8'h01, 8'h00);
    bus(1'b1, `NVM_OFF_DATA_LO, 8'h00);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h01);
    chk(`NVM_OFF_DATA_LO, 8'hFF, 8'h5A);
    chk(`NVM_OFF_CONTROL, 8'h01, 8'h00);
    // Reset in the middle of a data write
    bus(1'b1, `NVM_OFF_CONTROL, 8'h04);
    unlock_go(8'h06);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    chk(`NVM_OFF_CONTROL, 8'h8F, 8'h08);
    // Program word 1234h refused under the two wider protections
    bus(1'b1, `NVM_OFF_ADDR_HI, 8'h12);
    bus(1'b1, `NVM_OFF_ADDR_LO, 8'h34);
    bus(1'b1, `NVM_OFF_DATA_HI, 8'h2A);
    bus(1'b1, `NVM_OFF_DATA_LO, 8'hBC);
    for (int p = 0; p < 2; p++) begin
      self_write_protect <= p[1:0];
      bus(1'b1, `NVM_OFF_CONTROL, 8'h84);
      unlock_go(8'h86);
      chk(`NVM_OFF_STATUS, 8'h03, 8'h00);
    end
    // Outside the protected eighth it programs, with code protection on
    self_write_protect <= 2'b10;
    code_protect <= 1'b1;
    bus(1'b1, `NVM_OFF_CONTROL, 8'h84);
    unlock_go(8'h86);
    wait_idle();
    chk(`NVM_OFF_STATUS, 8'h01, 8'h01);
    bus(1'b1, `NVM_OFF_STATUS, 8'h00);
    pf_read(8'h81);
    chk(`NVM_OFF_DATA_LO, 8'hFF, 8'hBC);
    chk(`NVM_OFF_DATA_HI, 8'hFF, 8'h2A);
    pf_read(8'hC1);
    chk(`NVM_OFF_DATA_LO, 8'hFF, 8'hFF);
    // Latch-only write leaves the array and the done flag alone
    bus(1'b1, `NVM_OFF_ADDR_LO, 8'h35);
    bus(1'b1, `NVM_OFF_DATA_LO, 8'h11);
    bus(1'b1, `NVM_OFF_CONTROL, 8'hA4);
    unlock_go(8'hA6);
    wait_idle();
    chk(`NVM_OFF_STATUS, 8'h01, 8'h00);
    pf_read(8'h81);
    chk(`NVM_OFF_DATA_LO, 8'hFF, 8'hFF);
    // Row erase from an unaligned address clears the written word
    bus(1'b1, `NVM_OFF_ADDR_LO, 8'h34);
    bus(1'b1, `NVM_OFF_CONTROL, 8'h94);
    unlock_go(8'h96);
    wait_idle();
    chk(`NVM_OFF_CONTROL, 8'h10, 8'h00);
    pf_read(8'h81);
    chk(`NVM_OFF_DATA_HI, 8'hFF, 8'h3F);
    end_sim();
  end
endmodule : test_nv_memory_access_ctrl
